// >>> verilog/blprs_top.sv
// break state, low-power modes and reset-status registers behind an apb slave
module blprs_top
   import blprs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [DATA_W-1:0] pwdata_i,
   output logic [DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // break module and core
   input wire logic break_req_i,
   input wire logic break_exit_i,
   output logic force_swi_vector_o,
   output logic break_active_o,
   output logic flag_clear_allow_o,
   input wire logic stop_exec_i,
   input wire logic wait_exec_i,
   input wire logic irq_req_i,
   output logic clear_imask_o,
   output logic stack_start_o,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic base_clock_en_o,
   output logic crystal_clock_en_o,
   // configuration
   input wire logic watchdog_disable_i,
   input wire logic short_stop_recovery_i,
   output logic watchdog_run_o,
   // reset sources
   input wire logic ext_pin_rst_i,
   input wire logic watchdog_rst_i,
   input wire logic bad_opcode_rst_i,
   input wire logic bad_address_rst_i,
   input wire logic low_voltage_rst_i
);

   typedef struct packed {
      blprs_mode_t mode;
      blprs_wake_t cause;
      logic [CNT_W-1:0] target;
      logic pin_s1;
      logic pin_s2;
      logic break_active;
      logic clear_en;
      logic wakeup_flag;
      logic [BYTE_W-1:0] reset_cause;
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
      logic force_swi;
      logic clear_imask;
      logic stack_start;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic base_clk_en;
      logic xtal_clk_en;
      logic cnt_hold;
      logic watchdog_run;
      logic clear_allow;
   } blprs_state_t;

   blprs_state_t q;
   blprs_state_t next_q;
   logic [CNT_W-1:0] cnt;
   logic rst_evt;
   logic apb_done;
   logic hit_wake;
   logic hit_cause;
   logic hit_ctrl;

   // ==========================================================
   // system integration counter
   blprs_sim_counter u_counter (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .hold_i(next_q.cnt_hold), // next value, so the count is zero from the stop cycle on
      .count_o(cnt)
   );

   // ==========================================================
   // decode shared by the state update and the checks
   assign hit_wake = blprs_hit(paddr_i, IDX_BREAK_WAKE);
   assign hit_cause = blprs_hit(paddr_i, IDX_RESET_CAUSE);
   assign hit_ctrl = blprs_hit(paddr_i, IDX_BREAK_FLAG_CTRL);
   assign apb_done = psel_i & penable_i & q.pready;
   // pin reset only after both sync stages
   assign rst_evt = q.pin_s2 | watchdog_rst_i | bad_opcode_rst_i | bad_address_rst_i | low_voltage_rst_i;

   // ==========================================================
   // next state
   always_comb begin
      next_q = q;
      next_q.force_swi = 1'b0;
      next_q.clear_imask = 1'b0;
      next_q.stack_start = 1'b0;
      // pin synchroniser
      next_q.pin_s1 = ext_pin_rst_i;
      next_q.pin_s2 = q.pin_s1;

      // apb: one wait state so read data can come from a flop
      next_q.pready = psel_i & penable_i & ~q.pready;
      next_q.pslverr = 1'b0;
      if (psel_i & penable_i & ~q.pready) begin
         next_q.prdata = '0;
         if (hit_wake) begin
            next_q.prdata[BIT_WAKEUP] = q.wakeup_flag;
         end else if (hit_cause) begin
            next_q.prdata[BYTE_W-1:0] = q.reset_cause;
         end else if (hit_ctrl) begin
            next_q.prdata[BIT_CLEAR_EN] = q.clear_en; // R20
         end else begin
            next_q.pslverr = 1'b1; // R15
         end
      end

      // register writes and read side effects
      if (apb_done & pwrite_i & hit_wake & ~pwdata_i[BIT_WAKEUP]) begin
         next_q.wakeup_flag = 1'b0; // R16
      end
      if (apb_done & pwrite_i & hit_ctrl) begin
         next_q.clear_en = pwdata_i[BIT_CLEAR_EN]; // R20
      end
      if (apb_done & ~pwrite_i & hit_cause) begin
         next_q.reset_cause = ZERO_BYTE; // R17
      end

      // cause flags; a source in the read-clear cycle still lands
      if (q.pin_s2) begin
         next_q.reset_cause[BIT_EXT_PIN] = 1'b1; // R19 R21
      end
      if (watchdog_rst_i) begin
         next_q.reset_cause[BIT_WATCHDOG] = 1'b1; // R19 R21
      end
      if (bad_opcode_rst_i) begin
         next_q.reset_cause[BIT_BAD_OPCODE] = 1'b1; // R19 R21
      end
      if (bad_address_rst_i) begin
         next_q.reset_cause[BIT_BAD_ADDRESS] = 1'b1; // R19 R21
      end
      if (low_voltage_rst_i) begin
         next_q.reset_cause[BIT_LOW_VOLTAGE] = 1'b1; // R19 R21
      end
      if (rst_evt) begin
         next_q.wakeup_flag = 1'b0; // R16
      end

      // break state entry from normal running
      if (break_exit_i) begin
         next_q.break_active = 1'b0;
      end
      if (q.mode == BLPRS_RUN && break_req_i && !q.break_active) begin
         next_q.force_swi = 1'b1; // R1
         next_q.break_active = 1'b1;
      end

      // low-power sequencing
      unique case (q.mode)
         BLPRS_RUN: begin
            if (stop_exec_i) begin
               next_q.clear_imask = 1'b1; // R5
               next_q.mode = BLPRS_STOP_HOLD;
               next_q.cpu_clk_en = 1'b0;
               next_q.periph_clk_en = 1'b0;
               next_q.base_clk_en = 1'b0; // R10
               next_q.xtal_clk_en = 1'b0; // R10
               next_q.cnt_hold = 1'b1; // R10 R13
            end else if (wait_exec_i) begin
               next_q.clear_imask = 1'b1; // R5
               next_q.mode = BLPRS_WAIT;
               next_q.cpu_clk_en = 1'b0; // R6
            end
         end
         BLPRS_WAIT: begin
            if (rst_evt) begin
               next_q.mode = BLPRS_RUN; // R8
               next_q.cpu_clk_en = 1'b1;
            end else if (break_req_i) begin
               next_q.mode = BLPRS_RUN; // R8
               next_q.cpu_clk_en = 1'b1;
               next_q.wakeup_flag = 1'b1; // R8
               next_q.force_swi = 1'b1;
               next_q.break_active = 1'b1;
            end else if (irq_req_i) begin
               next_q.mode = BLPRS_RUN;
               next_q.cpu_clk_en = 1'b1;
               next_q.stack_start = 1'b1; // R7
            end
         end
         BLPRS_STOP_HOLD: begin
            if (rst_evt) begin
               // reset sequencing outside takes over, no recovery wait
               next_q.mode = BLPRS_RUN; // R11
               next_q.cpu_clk_en = 1'b1;
               next_q.periph_clk_en = 1'b1;
               next_q.base_clk_en = 1'b1;
               next_q.xtal_clk_en = 1'b1;
               next_q.cnt_hold = 1'b0;
            end else if (break_req_i || irq_req_i) begin
               next_q.mode = BLPRS_STOP_RECOV; // R11
               next_q.cause = break_req_i ? BLPRS_WAKE_BREAK : BLPRS_WAKE_IRQ;
               // a software clear in the same cycle still applies unless break sets
               next_q.wakeup_flag = next_q.wakeup_flag | break_req_i; // R8
               // recovery length picked at the wake event
               next_q.target = short_stop_recovery_i ? STOP_RECOV_SHORT : STOP_RECOV_LONG; // R12
               next_q.xtal_clk_en = 1'b1; // oscillator restarts first
               next_q.cnt_hold = 1'b0; // R13
            end
         end
         BLPRS_STOP_RECOV: begin
            if (rst_evt) begin
               next_q.mode = BLPRS_RUN;
               next_q.cpu_clk_en = 1'b1;
               next_q.periph_clk_en = 1'b1;
               next_q.base_clk_en = 1'b1;
            end else if (cnt == q.target) begin // counter reads one in the first recovery cycle
               next_q.mode = BLPRS_RUN; // R13
               next_q.cpu_clk_en = 1'b1;
               next_q.periph_clk_en = 1'b1;
               next_q.base_clk_en = 1'b1;
               next_q.cause = BLPRS_WAKE_NONE;
               if (q.cause == BLPRS_WAKE_IRQ) begin
                  next_q.stack_start = 1'b1; // R11
               end else begin
                  next_q.force_swi = 1'b1;
                  next_q.break_active = 1'b1;
               end
            end
         end
      endcase

      // derived outputs, taken from the next values so they track
      next_q.watchdog_run = ~watchdog_disable_i; // R9
      // peripherals hold their flags while this is low; cleared flags
      // are simply never restored, and a pending second step waits
      next_q.clear_allow = ~next_q.break_active | next_q.clear_en; // R2 R3 R4
   end

   // ==========================================================
   // state register; power-on style reset marks power_on_flag only
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.mode <= BLPRS_RUN;
         q.cause <= BLPRS_WAKE_NONE;
         q.reset_cause <= RST_RESET_CAUSE; // R18
         q.cpu_clk_en <= 1'b1;
         q.periph_clk_en <= 1'b1;
         q.base_clk_en <= 1'b1;
         q.xtal_clk_en <= 1'b1;
         q.watchdog_run <= 1'b1;
         q.clear_allow <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ==========================================================
   // outputs, all straight from flops
   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   assign force_swi_vector_o = q.force_swi;
   assign break_active_o = q.break_active;
   assign flag_clear_allow_o = q.clear_allow;
   assign clear_imask_o = q.clear_imask;
   assign stack_start_o = q.stack_start;
   assign cpu_clk_en_o = q.cpu_clk_en;
   assign periph_clk_en_o = q.periph_clk_en;
   assign base_clock_en_o = q.base_clk_en;
   assign crystal_clock_en_o = q.xtal_clk_en;
   assign watchdog_run_o = q.watchdog_run;

   // ==========================================================
   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   // helper: cycles spent in recovery
   logic [CNT_W-1:0] h_len;
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || q.mode != BLPRS_STOP_RECOV) begin
         h_len <= CNT_ZERO;
      end else begin
         h_len <= h_len + CNT_ONE;
      end
   end

   property p_break_swi;
      q.mode == BLPRS_RUN && break_req_i && !q.break_active |=> force_swi_vector_o && break_active_o;
   endproperty
   a_break_swi: assert property (p_break_swi) else $error("break did not force swi vector"); // R1

   property p_protect;
      break_active_o && !q.clear_en |-> !flag_clear_allow_o;
   endproperty
   a_protect: assert property (p_protect) else $error("flags clearable in break without enable"); // R2

   property p_free_outside;
      !break_active_o |-> flag_clear_allow_o;
   endproperty
   a_free_outside: assert property (p_free_outside) else $error("flags blocked outside break"); // R4

   property p_lowpower_entry;
      q.mode == BLPRS_RUN && (stop_exec_i || wait_exec_i) |=> clear_imask_o && !cpu_clk_en_o ##1 !clear_imask_o;
   endproperty
   a_lowpower_entry: assert property (p_lowpower_entry) else $error("low-power entry wrong"); // R5

   property p_wait_clocks;
      q.mode == BLPRS_WAIT |-> !cpu_clk_en_o && periph_clk_en_o;
   endproperty
   a_wait_clocks: assert property (p_wait_clocks) else $error("wait clock gating wrong"); // R6

   property p_wait_irq;
      q.mode == BLPRS_WAIT && irq_req_i && !break_req_i && !rst_evt |=> stack_start_o && cpu_clk_en_o;
   endproperty
   a_wait_irq: assert property (p_wait_irq) else $error("wait interrupt exit wrong"); // R7

   property p_break_wake;
      (q.mode == BLPRS_WAIT || q.mode == BLPRS_STOP_HOLD) && break_req_i && !rst_evt |=> q.wakeup_flag;
   endproperty
   a_break_wake: assert property (p_break_wake) else $error("break wake flag not set"); // R8

   property p_watchdog;
      1'b1 |=> watchdog_run_o == !$past(watchdog_disable_i);
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog enable wrong"); // R9

   property p_stop_hold;
      q.mode == BLPRS_STOP_HOLD |-> !base_clock_en_o && !crystal_clock_en_o && cnt == CNT_ZERO;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop hold state wrong"); // R10

   property p_recov_len;
      stack_start_o && $past(q.mode) == BLPRS_STOP_RECOV |-> h_len == q.target;
   endproperty
   a_recov_len: assert property (p_recov_len) else $error("stop recovery length wrong"); // R12

   property p_recov_no_stack;
      q.mode == BLPRS_STOP_RECOV |-> !stack_start_o;
   endproperty
   a_recov_no_stack: assert property (p_recov_no_stack) else $error("stacking during recovery"); // R11

   property p_wake_clear;
      apb_done && pwrite_i && hit_wake && !pwdata_i[BIT_WAKEUP] && q.mode == BLPRS_RUN |=> !q.wakeup_flag;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("wake flag not cleared by zero"); // R16

   property p_read_clear;
      apb_done && !pwrite_i && hit_cause && !rst_evt |=> q.reset_cause == ZERO_BYTE;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("cause register not cleared on read"); // R17

   property p_cause_keep;
      watchdog_rst_i && !(apb_done && !pwrite_i && hit_cause)
         |=> q.reset_cause[BIT_WATCHDOG] && q.reset_cause[BIT_POWER_ON] == $past(q.reset_cause[BIT_POWER_ON]);
   endproperty
   a_cause_keep: assert property (p_cause_keep) else $error("watchdog cause flag wrong"); // R21

   c_wait_irq: cover property (q.mode == BLPRS_WAIT ##1 stack_start_o);
   c_stop_recov: cover property ($past(q.mode) == BLPRS_STOP_RECOV && stack_start_o);
   c_break_wake: cover property (q.mode == BLPRS_STOP_HOLD && break_req_i ##1 q.wakeup_flag);
   c_read_clear: cover property (apb_done && !pwrite_i && hit_cause);

endmodule

// >>> inc/blprs_pkg.sv
// constants, types and helpers shared by the break, low-power and reset-status block
// Summary of operation
// [R1] a break request forces the core to fetch the software interrupt vector
// [R2] during break, peripheral flags clear only when break_clear_enable is set
// [R3] a flag cleared during break stays cleared after break ends
// [R4] two-step clears stay blocked in break, complete normally after leaving break
// [R5] stop or wait clears the core interrupt mask and stops the core clock
// [R6] wait gates core clocks while peripheral clocks keep running
// [R7] enabled interrupt wakes from wait; stacking starts one cycle later
// [R8] reset or break also ends wait; break in wait or stop sets break_wakeup_flag
// [R9] watchdog runs, also in wait, while watchdog_disable is zero
// [R10] stop resets the counter and disables base_clock_out and crystal_clock
// [R11] stop ends on interrupt, reset or break; interrupt stacking after recovery
// [R12] recovery lasts 4096 crystal_clock cycles, or 32 with short_stop_recovery
// [R13] counter held in reset during stop, then times the recovery period
// [R14] crystal systems should keep short_stop_recovery clear for full delay
// [R15] three registers at indices FE00, FE01 and FE03, nothing at FE02
// [R16] break_wakeup_flag clears on written zero or any reset, else stays set
// [R17] reading reset_cause_reg clears all its flags
// [R18] power-on reset sets power_on_flag and clears the other cause flags
// [R19] six cause flags: power-on, pin, watchdog, opcode, address fetch, low voltage
// [R20] break_clear_enable is read/write; software sets it to clear flags in break
// [R21] other resets set only their own flag, others kept until read or power-on
package blprs_pkg;

   // ==========================================================
   // register map: printed offsets are word indices
   localparam int DATA_W = 32;
   localparam int BYTE_W = 8;
   localparam logic [15:0] IDX_BREAK_WAKE = 16'hFE00;
   localparam logic [15:0] IDX_RESET_CAUSE = 16'hFE01;
   localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hFE03;

   // ==========================================================
   // field positions
   localparam int BIT_WAKEUP = 1;
   localparam int BIT_POWER_ON = 7;
   localparam int BIT_EXT_PIN = 6;
   localparam int BIT_WATCHDOG = 5;
   localparam int BIT_BAD_OPCODE = 4;
   localparam int BIT_BAD_ADDRESS = 3;
   localparam int BIT_LOW_VOLTAGE = 1;
   localparam int BIT_CLEAR_EN = 7;

   // ==========================================================
   // reset values
   localparam logic [7:0] RST_RESET_CAUSE = 8'h80;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ==========================================================
   // stop recovery timing, in crystal_clock cycles
   localparam int CNT_W = 13;
   localparam logic [CNT_W-1:0] STOP_RECOV_LONG = 13'h1000;
   localparam logic [CNT_W-1:0] STOP_RECOV_SHORT = 13'h0020;
   localparam logic [CNT_W-1:0] CNT_ZERO = 13'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;

   // ==========================================================
   // modes and wake causes
   typedef enum logic [1:0] {
      BLPRS_RUN,
      BLPRS_WAIT,
      BLPRS_STOP_HOLD,
      BLPRS_STOP_RECOV
   } blprs_mode_t;

   typedef enum logic [1:0] {
      BLPRS_WAKE_NONE,
      BLPRS_WAKE_IRQ,
      BLPRS_WAKE_BREAK
   } blprs_wake_t;

   // word-aligned byte address match for a register index
   function automatic logic blprs_hit(input logic [31:0] addr, input logic [15:0] idx);
      return addr == {14'h0000, idx, 2'b00};
   endfunction

endpackage

// >>> verilog/blprs_sim_counter.sv
// system integration counter: free running, cleared while held
module blprs_sim_counter
   import blprs_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic hold_i,
   output logic [CNT_W-1:0] count_o
);

   typedef struct packed {
      logic [CNT_W-1:0] count;
   } blprs_cnt_state_t;

   blprs_cnt_state_t q;
   blprs_cnt_state_t next_q;

   // ==========================================================
   // count, or sit at zero while held
   always_comb begin
      next_q = q;
      if (hold_i) begin
         next_q.count = CNT_ZERO; // R13
      end else begin
         next_q.count = q.count + CNT_ONE;
      end
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign count_o = q.count;

endmodule

// >>> sim/blprs_core_model.sv
// stand-in for the core and break module on the far side of the block
module blprs_core_model
(
   input wire logic do_wait_i,
   input wire logic do_stop_i,
   input wire logic do_break_i,
   input wire logic do_exit_i,
   input wire logic cpu_clk_en_i,
   output logic wait_exec_o,
   output logic stop_exec_o,
   output logic break_req_o,
   output logic break_exit_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // instruction side
   // an unclocked core executes nothing, so no stop/wait while gated
   assign wait_exec_o = do_wait_i & cpu_clk_en_i;
   assign stop_exec_o = do_stop_i & cpu_clk_en_i & !do_wait_i;

   // ==========================================================
   // break module side
   // break works whether or not the core runs, so it is never gated
   assign break_req_o = do_break_i;
   assign break_exit_o = do_exit_i;
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the break, low-power and reset-status block
module tb_top
   import blprs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // stimulus and observation
   localparam logic [31:0] A_WAKE = 32'h0003F800;
   localparam logic [31:0] A_CAUSE = 32'h0003F804;
   localparam logic [31:0] A_HOLE = 32'h0003F808;
   localparam logic [31:0] A_CTRL = 32'h0003F80C;
   logic sys_clk, rst_b, psel, penable, pwrite, irq, wdis, ssr, do_wait, do_stop, do_brk, do_exit, perr;
   logic [31:0] paddr, pwdata, rdata, prdata;
   logic [4:0] rsrc, m1, m2; // pin, watchdog, opcode, address, low voltage
   logic pready, pslverr, software_interrupt_vector, bact, fca, cimask, stk, cpuen, peren, basen, xtalen, wdrun;
   logic wexec, sexec, breq, bexit;
   int err_total, n_compared, seed, n, i;

   blprs_top blprs_top_i (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .break_req_i(breq), .break_exit_i(bexit), .force_swi_vector_o(software_interrupt_vector),
      .break_active_o(bact), .flag_clear_allow_o(fca), .stop_exec_i(sexec), .wait_exec_i(wexec),
      .irq_req_i(irq), .clear_imask_o(cimask), .stack_start_o(stk), .cpu_clk_en_o(cpuen),
      .periph_clk_en_o(peren), .base_clock_en_o(basen), .crystal_clock_en_o(xtalen),
      .watchdog_disable_i(wdis), .short_stop_recovery_i(ssr), .watchdog_run_o(wdrun),
      .ext_pin_rst_i(rsrc[4]), .watchdog_rst_i(rsrc[3]), .bad_opcode_rst_i(rsrc[2]),
      .bad_address_rst_i(rsrc[1]), .low_voltage_rst_i(rsrc[0]));

   blprs_core_model blprs_core_model_i (.do_wait_i(do_wait), .do_stop_i(do_stop), .do_break_i(do_brk),
      .do_exit_i(do_exit), .cpu_clk_en_i(cpuen), .wait_exec_o(wexec), .stop_exec_o(sexec),
      .break_req_o(breq), .break_exit_o(bexit));

   // ==========================================================
   // clock, 50 ns period
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // helpers
   task automatic give_verdict;
      $display("counts: compared %0d mismatched %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // apb master: setup, access, hold until pready is sampled high
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int t;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) begin
         err_total++;
         $display("unexpected at %0t: no pready", $time);
         give_verdict();
      end
      rdata = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string m);
      apb(1'b0, a, 32'h00000000);
      chk(rdata, exp, m);
   endtask

   // count edges until stacking or the vector fetch shows, bounded
   task automatic wait_for(input logic want_swi, input int lim, output int c);
      c = 0;
      do begin
         @(posedge sys_clk);
         c++;
      end while (((want_swi ? software_interrupt_vector : stk) !== 1'b1) && c < lim);
      if (c >= lim) begin
         err_total++;
         $display("unexpected at %0t: wake timed out", $time);
         give_verdict();
      end
   endtask

   // one stop or wait instruction, then entry checks
   task automatic enter(input logic stop);
      if (stop) begin
         do_stop <= 1'b1;
      end else begin
         do_wait <= 1'b1;
      end
      step(1);
      do_stop <= 1'b0;
      do_wait <= 1'b0;
      step(1);
      chk(cimask, 1'b1, "mask clear");
      chk(cpuen, 1'b0, "core clock");
   endtask

   task automatic brk_exit;
      do_exit <= 1'b1;
      step(1);
      do_exit <= 1'b0;
      step(2);
   endtask

   function automatic logic [31:0] cause_of(input logic [4:0] m);
      cause_of = 32'h00000000;
      cause_of[BIT_EXT_PIN] = m[4];
      cause_of[BIT_WATCHDOG] = m[3];
      cause_of[BIT_BAD_OPCODE] = m[2];
      cause_of[BIT_BAD_ADDRESS] = m[1];
      cause_of[BIT_LOW_VOLTAGE] = m[0];
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      {rst_b, psel, penable, pwrite, irq, wdis, ssr, do_wait, do_stop, do_brk, do_exit} = '0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      rsrc = 5'h00;
      err_total = 0;
      n_compared = 0;
      seed = 23;
      step(16);
      rst_b <= 1'b1;
      rd(A_CAUSE, 32'h00000080, "power-on cause");
      rd(A_CAUSE, 32'h00000000, "cause after read");
      rd(A_WAKE, 32'h00000000, "wake reset");
      rd(A_CTRL, 32'h00000000, "ctrl reset");
      apb(1'b1, A_CTRL, 32'h00000080);
      rd(A_CTRL, 32'h00000080, "ctrl rw");
      apb(1'b1, A_CAUSE, 32'h000000FF);
      rd(A_CAUSE, 32'h00000000, "cause read only");
      rd(A_HOLE, 32'h00000000, "hole data");
      chk(perr, 1'b1, "hole error");
      apb(1'b1, A_CTRL, 32'h00000000);
      $display("test registers done");
      for (i = 0; i < 4; i++) begin
         wdis <= 1'($random(seed));
         step(2);
         chk(wdrun, !wdis, "watchdog run");
      end
      wdis <= 1'b0;
      $display("test watchdog done");
      // break from run, flag protection then enable
      do_brk <= 1'b1;
      step(1);
      do_brk <= 1'b0;
      step(1);
      chk({software_interrupt_vector, bact, fca}, 3'b110, "break entry");
      apb(1'b1, A_CTRL, 32'h00000080);
      step(2);
      chk(fca, 1'b1, "clear allowed");
      brk_exit();
      chk({bact, fca}, 2'b01, "break left");
      apb(1'b1, A_CTRL, 32'h00000000);
      $display("test break done");
      // wait left by interrupt, peripherals kept clocked
      enter(1'b0);
      chk(peren, 1'b1, "periph clock");
      step(3);
      irq <= 1'b1;
      wait_for(1'b0, 10, n);
      irq <= 1'b0;
      chk(32'(n), 32'd2, "wait stacking");
      // wait left by break, wake flag set then written away
      enter(1'b0);
      do_brk <= 1'b1;
      step(1);
      do_brk <= 1'b0;
      step(1);
      chk({software_interrupt_vector, cpuen}, 2'b11, "wait break");
      rd(A_WAKE, 32'h00000002, "wake flag");
      apb(1'b1, A_WAKE, 32'h00000000);
      rd(A_WAKE, 32'h00000000, "wake cleared");
      brk_exit();
      // wait left by a reset event
      enter(1'b0);
      rsrc <= 5'h08;
      step(1);
      rsrc <= 5'h00;
      step(1);
      chk(cpuen, 1'b1, "wait reset");
      rd(A_CAUSE, 32'h00000020, "watchdog cause");
      $display("test wait done");
      // stop: short, long, then short by break
      for (i = 0; i < 3; i++) begin
         ssr <= (i != 1);
         step(1);
         enter(1'b1);
         chk({peren, basen, xtalen}, 3'b000, "stop clocks");
         step(5);
         if (i == 2) begin
            do_brk <= 1'b1;
         end else begin
            irq <= 1'b1;
         end
         wait_for(i == 2, 5000, n);
         do_brk <= 1'b0;
         irq <= 1'b0;
         chk(32'(n), (i != 1) ? 32'd34 : 32'd4098, "recovery time");
         chk({cpuen, peren, basen, xtalen}, 4'hF, "clocks back");
         if (i == 2) begin
            rd(A_WAKE, 32'h00000002, "stop wake flag");
            brk_exit();
         end
      end
      // stop left by a reset event, no recovery wait
      enter(1'b1);
      rsrc <= 5'h02;
      step(1);
      rsrc <= 5'h00;
      step(1);
      chk({cpuen, peren, basen, xtalen}, 4'hF, "stop reset");
      rd(A_CAUSE, 32'h00000008, "address cause");
      $display("test stop done");
      // reset causes accumulate until read
      for (i = 0; i < 8; i++) begin
         m1 = (i == 0) ? 5'h10 : 5'($random(seed));
         m2 = (i == 0) ? 5'h01 : 5'($random(seed));
         rsrc <= m1;
         step(1);
         rsrc <= m2;
         step(1);
         rsrc <= 5'h00;
         step(4);
         rd(A_CAUSE, cause_of(m1 | m2), "cause flags");
      end
      // power-on reset in mid-run drops the other cause flags
      rsrc <= 5'h04;
      step(1);
      rsrc <= 5'h00;
      rst_b <= 1'b0;
      step(2);
      rst_b <= 1'b1;
      rd(A_CAUSE, 32'h00000080, "power-on clears causes");
      rd(A_WAKE, 32'h00000000, "wake after reset");
      $display("test causes done");
      give_verdict();
   end
endmodule
